// file: common/mrs_pkg.sv
`default_nettype none

package mrs_pkg;

    // Clock and derived rates
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned SYM_HZ = 2400;
    localparam int unsigned TRN_HZ = 4800;
    localparam int unsigned RATE_HI_HZ = 14400;
    localparam int unsigned RATE_LO_HZ = 12000;
    localparam int unsigned SYM_DIV = CLK_HZ / SYM_HZ;
    localparam int unsigned TRN_DIV = CLK_HZ / TRN_HZ;
    localparam logic [13:0] HI_DIV = 14'(CLK_HZ / RATE_HI_HZ);
    localparam logic [13:0] LO_DIV = 14'(CLK_HZ / RATE_LO_HZ);

    // Retry and guard interval, default for the programmable ports
    localparam int unsigned GUARD_MS = 1200;
    localparam logic [24:0] GUARD_CYC = 25'(CLK_HZ / 1000 * GUARD_MS);
    localparam logic [24:0] SINCE_MAX = 25'h1ffffff;

    // Segment lengths in symbol intervals
    localparam logic [11:0] SEG1_SYM = 12'h100;
    localparam logic [11:0] SEG2_SYM = 12'hba0;
    localparam logic [11:0] SEG3_SYM = 12'h040;
    localparam logic [11:0] SEG4_SYM = 12'h030;

    // Scrambler
    localparam int unsigned SCR_LEN = 23;
    localparam int unsigned TAP_A = 17;
    localparam int unsigned TAP_B = 22;
    // Bit 0 holds the newest scrambled bit
    localparam logic [22:0] SCR_INIT = 23'h2ecdd5;

    // Rate word layout
    localparam logic [15:0] RW_FIXED = 16'h8880;
    localparam int unsigned RW_B6 = 6;
    localparam int unsigned RW_B8 = 8;
    localparam int unsigned RW_B9 = 9;
    localparam int unsigned RW_B10 = 10;
    localparam int unsigned RW_B12 = 12;
    localparam int unsigned RW_B13 = 13;
    localparam int unsigned RW_B14 = 14;

    // Multiplexer
    localparam logic [3:0] MUX_CFG_1 = 4'h1;
    localparam logic [2:0] BITS_HI = 3'h6;
    localparam logic [2:0] BITS_LO = 3'h5;

    // Transmit timing source
    localparam logic [1:0] TXT_INT = 2'h0;
    localparam logic [1:0] TXT_EXT = 2'h1;
    localparam logic [1:0] TXT_LOOP = 2'h2;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_SEG1 = 6'h02,
        ST_EQ_TRAIN = 6'h04,
        ST_RATE = 6'h08,
        ST_ONES = 6'h10,
        ST_DATA = 6'h20
    } mrs_state_t;

endpackage

`default_nettype wire

// file: rtl/mrs_fifo.sv
`default_nettype none

// Depth must be a power of two
module mrs_fifo #(
    parameter int unsigned W = 1,
    parameter int unsigned D = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Flush
    input wire logic clear,
    // Fill side
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int unsigned AW = $clog2(D);

    logic [W-1:0] mem_q [D];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic [AW:0] used;
    logic push;
    logic pop;

    assign used = wr_q - rd_q;
    assign in_ready = (used != (AW+1)'(D));
    assign out_valid = (used != '0);
    assign out_data = mem_q[rd_q[AW-1:0]];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else if (clear) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_q + (AW+1)'(push);
            rd_q <= rd_q + (AW+1)'(pop);
        end
    end

    // Storage needs no reset; the pointers guard it
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end

endmodule

`default_nettype wire

// file: rtl/mrs_top.sv
// Functional notes
// RULE1 - Loss of equalization launches a local synchronizing sequence.
// RULE2 - Remote sync plus rate sequence may launch ours anytime, ignoring request-to-send.
// RULE3 - A change of rate or multiplexer configuration launches a sequence.
// RULE4 - No remote sync within the wait after our sequence: send again.
// RULE5 - Receive failure resends at highest common rate, unless sent within guard time.
// RULE6 - Unprovoked remote sync with good receive lock gets exactly one answer.
// RULE7 - Equalization-loss launches keep the previous multiplexer configuration.
// RULE8 - Multiplexer combines sub-channels into one aggregate stream for modulator bits.
// RULE9 - A sub-channel's earliest bit goes to its earliest modulator slot.
// RULE10 - Ready-for-sending is off on every port during synchronization.
// RULE11 - Port A rate selector acts in configuration 1 as without multiplexer.
// RULE12 - Port A local loop applies to all ports outside configuration 1.
// RULE13 - Test indicator per port, or on all ports together for whole test.
// RULE14 - Port buffer initialized on request-to-send rise, repositioned on overflow.
// RULE15 - Optionally also initialize port buffers whenever a sequence is sent.
// RULE16 - Buffer needed only for terminal timing, except the external timing port.
// RULE17 - Scrambled bit is input XOR own outputs 18 and 23 bits earlier.
// RULE18 - Scrambler register preset to fixed state before equalizer conditioning.
// RULE19 - Scrambler steps at 4800 Hz in segments 2, 3; data rate after.
// RULE20 - Scrambler input: ones in segments 2 and 4, rate word, then data.
// RULE21 - Descrambler output is received bit XOR received bits 18, 23 earlier.
// RULE22 - A resynchronizing receiver drops ready-for-sending and starts the sequence.
// RULE23 - Segment 1 lasts 256 symbol intervals.
// RULE24 - Segment 2 lasts 2976 symbol intervals.
// RULE25 - After 48-symbol segment 4, ready-for-sending on and user data scrambled.
// RULE26 - Retry wait and guard interval are programmable cycle counts.
// RULE27 - Port buffer overflow sets a sticky status bit.
`default_nettype none

module mrs_top
    import mrs_pkg::*;
#(
    parameter int unsigned NPORT = 6,
    parameter int unsigned SYM_DIV_P = SYM_DIV,
    parameter int unsigned TRN_DIV_P = TRN_DIV,
    parameter int unsigned BUF_DEPTH = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Receiver events
    input wire logic eq_lost,
    input wire logic remote_sync_det,
    input wire logic rx_sync_ok,
    input wire logic rx_fail,
    input wire logic remote_cap_hi,
    // Rate and configuration
    input wire logic rate_hi_sw,
    input wire logic rate_sel_a_en,
    input wire logic rate_sel_a,
    input wire logic mux_en,
    input wire logic [3:0] mux_cfg_sw,
    input wire logic [24:0] cfg_retry_cycles,
    input wire logic [24:0] cfg_guard_cycles,
    input wire logic buf_init_on_sync,
    // Timing arrangement
    input wire logic [1:0] tx_timing_mode,
    input wire logic [2:0] ext_timing_port,
    input wire logic [NPORT-1:0] port_dte_timing,
    // Port circuits
    input wire logic [NPORT-1:0] port_rts,
    input wire logic [NPORT-1:0] port_txd,
    input wire logic [NPORT-1:0] port_txd_valid,
    output logic [NPORT-1:0] port_txd_ready,
    output logic [NPORT-1:0] port_cts,
    input wire logic loop_req_a,
    output logic [NPORT-1:0] port_loop,
    input wire logic [NPORT-1:0] test_port,
    input wire logic test_all,
    output logic [NPORT-1:0] port_test_ind,
    // Buffer status
    output logic [NPORT-1:0] buf_needed,
    output logic [NPORT-1:0] buf_ovf,
    input wire logic [NPORT-1:0] buf_ovf_clr,
    // Line side
    output mrs_state_t tx_segment,
    output logic tx_bit,
    output logic tx_bit_valid,
    output logic [3:0] active_cfg,
    output logic active_hi,
    input wire logic rx_bit,
    input wire logic rx_bit_valid,
    output logic rx_data,
    output logic rx_data_valid
);

    // Slot owners, one nibble per modulator bit, earliest slot lowest
    function automatic logic [23:0] slot_map(input logic hi, input logic [3:0] cfg);
        logic [23:0] m;
        m = 24'h000000;
        if (hi) begin
            unique case (cfg)
                4'h2: m = 24'h100000;
                4'h3: m = 24'h110000;
                4'h4: m = 24'h210000;
                4'h5: m = 24'h111000;
                4'h6: m = 24'h211000;
                4'h7: m = 24'h321000;
                4'h8: m = 24'h221100;
                4'h9: m = 24'h321100;
                4'ha: m = 24'h432100;
                4'hb: m = 24'h543210;
                default: m = 24'h000000;
            endcase
        end else begin
            unique case (cfg)
                4'h2: m = 24'h010000;
                4'h3: m = 24'h011000;
                4'h4: m = 24'h021000;
                4'h5: m = 24'h021100;
                4'h6: m = 24'h032100;
                4'h7: m = 24'h043210;
                default: m = 24'h000000;
            endcase
        end
        return m;
    endfunction

    function automatic logic [15:0] rate_word(input logic hi, input logic mux,
                                              input logic [3:0] cfg);
        logic [15:0] w;
        w = RW_FIXED;
        w[RW_B8] = 1'b1;
        w[RW_B9] = hi;
        w[RW_B14] = mux;
        if (mux) begin
            w[RW_B6] = cfg[3];
            w[RW_B10] = cfg[2];
            w[RW_B12] = cfg[1];
            w[RW_B13] = cfg[0];
        end
        return w;
    endfunction

    mrs_state_t state_q, state_d;
    logic [13:0] sym_cnt_q, trn_cnt_q, dat_cnt_q;
    logic sym_tick, trn_tick, dat_tick;
    logic [11:0] seg_cnt_q, seg_last;
    logic seg_done, tx_active;
    logic [24:0] since_q;
    logic initiated_q, pend_ans_q, chg_pend_q;
    logic [3:0] sel_cfg_q, act_cfg_q, cfg_sel;
    logic sel_hi_q, act_hi_q, sel_hi, cfg_changed;
    logic launch_cfg, launch_retry, launch_fail, launch_ans, launch_own, launch;
    logic [3:0] bit_idx_q;
    logic [2:0] slot_q, slot_last;
    logic [2:0] owner;
    logic [23:0] map;
    logic [15:0] rword;
    logic [SCR_LEN-1:0] scr_q, desc_q;
    logic scr_step, scr_in, scr_out, user_bit;
    logic tx_bit_q, tx_bit_valid_q, rx_data_q, rx_data_valid_q;
    logic [NPORT-1:0] rts_q, ovf_q, ovf_set, fifo_rdy, fifo_vld, fifo_dat, pop, clr;

    // Rate enables
    assign sym_tick = (sym_cnt_q == 14'(SYM_DIV_P - 1));
    assign trn_tick = (trn_cnt_q == 14'(TRN_DIV_P - 1));
    assign dat_tick = (dat_cnt_q == ((act_hi_q ? HI_DIV : LO_DIV) - 14'h0001));

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sym_cnt_q <= 14'h0000;
            trn_cnt_q <= 14'h0000;
            dat_cnt_q <= 14'h0000;
        end else begin
            sym_cnt_q <= sym_tick ? 14'h0000 : sym_cnt_q + 14'h0001;
            trn_cnt_q <= trn_tick ? 14'h0000 : trn_cnt_q + 14'h0001;
            dat_cnt_q <= dat_tick ? 14'h0000 : dat_cnt_q + 14'h0001;
        end
    end

    // Effective selection; rate selector on port A only counts in configuration 1
    assign cfg_sel = mux_en ? mux_cfg_sw : MUX_CFG_1;
    assign sel_hi = (cfg_sel == MUX_CFG_1 && rate_sel_a_en) ? rate_sel_a : rate_hi_sw; // RULE11
    assign cfg_changed = (cfg_sel != sel_cfg_q) || (sel_hi != sel_hi_q);

    // Launch decisions; an answer never counts as our own initiation
    assign tx_active = (state_q == ST_SEG1) || (state_q == ST_EQ_TRAIN) ||
                       (state_q == ST_RATE) || (state_q == ST_ONES);
    assign launch_cfg = chg_pend_q || (state_q == ST_IDLE); // RULE3
    assign launch_retry = initiated_q && (since_q >= cfg_retry_cycles); // RULE4
    assign launch_fail = rx_fail && (since_q >= cfg_guard_cycles); // RULE5
    assign launch_ans = pend_ans_q && rx_sync_ok; // RULE6
    assign launch_own = eq_lost || launch_cfg || launch_retry || launch_fail; // RULE1
    assign launch = !tx_active && (launch_own || launch_ans); // RULE22

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sel_cfg_q <= MUX_CFG_1;
            sel_hi_q <= 1'b0;
            chg_pend_q <= 1'b0;
            initiated_q <= 1'b0;
            pend_ans_q <= 1'b0;
            since_q <= SINCE_MAX;
        end else begin
            sel_cfg_q <= cfg_sel;
            sel_hi_q <= sel_hi;
            // A launch that takes the new selection has already served the change
            chg_pend_q <= (cfg_changed || chg_pend_q) && !(launch && !launch_fail && !eq_lost);
            // Remote sync while we await one is the expected reply
            if (launch && launch_own) begin
                initiated_q <= 1'b1;
            end else if (remote_sync_det) begin
                initiated_q <= 1'b0;
            end
            // Answer armed regardless of request-to-send
            pend_ans_q <= (remote_sync_det && !initiated_q) || (pend_ans_q && !launch); // RULE2
            if (tx_active || launch) begin
                since_q <= 25'h0000000; // RULE26
            end else if (since_q != SINCE_MAX) begin
                since_q <= since_q + 25'h0000001;
            end
        end
    end

    // Active rate and configuration for the next sequence
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            act_cfg_q <= MUX_CFG_1;
            act_hi_q <= 1'b0;
        end else if (launch) begin
            if (launch_fail) begin
                act_hi_q <= sel_hi && remote_cap_hi; // RULE5
            end else if (!eq_lost) begin // RULE7
                act_cfg_q <= cfg_sel;
                act_hi_q <= sel_hi;
            end
        end
    end

    // Segment sequencer
    assign seg_last = (state_q == ST_SEG1) ? SEG1_SYM - 12'h001 : // RULE23
                      (state_q == ST_EQ_TRAIN) ? SEG2_SYM - 12'h001 : // RULE24
                      (state_q == ST_RATE) ? SEG3_SYM - 12'h001 :
                      SEG4_SYM - 12'h001;
    assign seg_done = tx_active && sym_tick && (seg_cnt_q == seg_last);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: if (launch) state_d = ST_SEG1;
            ST_SEG1: if (seg_done) state_d = ST_EQ_TRAIN;
            ST_EQ_TRAIN: if (seg_done) state_d = ST_RATE;
            ST_RATE: if (seg_done) state_d = ST_ONES;
            ST_ONES: if (seg_done) state_d = ST_DATA; // RULE25
            ST_DATA: if (launch) state_d = ST_SEG1;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            seg_cnt_q <= 12'h000;
        end else begin
            state_q <= state_d;
            if (launch || seg_done) begin
                seg_cnt_q <= 12'h000;
            end else if (tx_active && sym_tick) begin
                seg_cnt_q <= seg_cnt_q + 12'h001;
            end
        end
    end

    // Aggregate multiplexer: slots filled in time order per sub-channel
    assign map = slot_map(act_hi_q, act_cfg_q); // RULE8
    assign slot_last = (act_hi_q ? BITS_HI : BITS_LO) - 3'h1;
    assign owner = map[{slot_q, 2'b00} +: 3]; // RULE9
    // An empty buffer sends a one rather than stalling the line
    assign user_bit = !buf_needed[owner] ? port_txd[owner] :
                      (fifo_vld[owner] ? fifo_dat[owner] : 1'b1);

    // Scrambler
    assign rword = rate_word(act_hi_q, mux_en, act_cfg_q);
    assign scr_step = ((state_q == ST_EQ_TRAIN || state_q == ST_RATE) && trn_tick) || // RULE19
                      ((state_q == ST_ONES || state_q == ST_DATA) && dat_tick);
    assign scr_in = (state_q == ST_DATA) ? user_bit : // RULE20
                    (state_q == ST_RATE) ? rword[bit_idx_q] : 1'b1;
    assign scr_out = scr_in ^ scr_q[TAP_A] ^ scr_q[TAP_B]; // RULE17

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            scr_q <= SCR_INIT;
            bit_idx_q <= 4'h0;
            slot_q <= 3'h0;
            tx_bit_q <= 1'b1;
            tx_bit_valid_q <= 1'b0;
        end else begin
            if (state_q == ST_SEG1 && seg_done) begin
                scr_q <= SCR_INIT; // RULE18
            end else if (scr_step) begin
                scr_q <= {scr_q[SCR_LEN-2:0], scr_out};
            end
            if (launch) begin
                bit_idx_q <= 4'h0;
            end else if (state_q == ST_RATE && trn_tick) begin
                bit_idx_q <= bit_idx_q + 4'h1;
            end
            if (state_q != ST_DATA) begin
                slot_q <= 3'h0;
            end else if (dat_tick) begin
                slot_q <= (slot_q == slot_last) ? 3'h0 : slot_q + 3'h1;
            end
            if (scr_step) begin
                tx_bit_q <= scr_out;
            end
            tx_bit_valid_q <= scr_step;
        end
    end

    // Descrambler, feed-forward only so a line error cannot persist
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            desc_q <= '0;
            rx_data_q <= 1'b0;
            rx_data_valid_q <= 1'b0;
        end else begin
            if (rx_bit_valid) begin
                desc_q <= {desc_q[SCR_LEN-2:0], rx_bit};
                rx_data_q <= rx_bit ^ desc_q[TAP_A] ^ desc_q[TAP_B]; // RULE21
            end
            rx_data_valid_q <= rx_bit_valid;
        end
    end

    // Port buffers
    for (genvar p = 0; p < NPORT; p++) begin : g_port
        assign buf_needed[p] = port_dte_timing[p] &&
            !(tx_timing_mode == TXT_EXT && ext_timing_port == 3'(p)); // RULE16
        assign pop[p] = (state_q == ST_DATA) && dat_tick && (owner == 3'(p)) && buf_needed[p];
        assign ovf_set[p] = buf_needed[p] && port_txd_valid[p] && !fifo_rdy[p];
        assign clr[p] = (port_rts[p] && !rts_q[p]) || ovf_set[p] || // RULE14
                        (buf_init_on_sync && launch); // RULE15
        assign port_txd_ready[p] = !buf_needed[p] || fifo_rdy[p];

        mrs_fifo #(
            .W(1),
            .D(BUF_DEPTH)
        ) u_buf (
            .clk(sys_clk),
            .reset_n(reset_n),
            .clear(clr[p]),
            .in_valid(port_txd_valid[p] && buf_needed[p]),
            .in_data(port_txd[p]),
            .in_ready(fifo_rdy[p]),
            .out_valid(fifo_vld[p]),
            .out_data(fifo_dat[p]),
            .out_ready(pop[p])
        );
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rts_q <= '0;
            ovf_q <= '0;
        end else begin
            rts_q <= port_rts;
            ovf_q <= ovf_set | (ovf_q & ~buf_ovf_clr); // RULE27
        end
    end

    // Port circuits
    assign port_cts = (state_q == ST_DATA) ? port_rts : '0; // RULE10
    assign port_loop = !loop_req_a ? '0 :
                       (act_cfg_q == MUX_CFG_1) ? NPORT'(1) : '1; // RULE12
    assign port_test_ind = test_port | {NPORT{test_all}}; // RULE13

    assign buf_ovf = ovf_q;
    assign tx_segment = state_q;
    assign tx_bit = tx_bit_q;
    assign tx_bit_valid = tx_bit_valid_q;
    assign active_cfg = act_cfg_q;
    assign active_hi = act_hi_q;
    assign rx_data = rx_data_q;
    assign rx_data_valid = rx_data_valid_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence s_ans_launch;
        pend_ans_q && rx_sync_ok && !tx_active && !launch_own;
    endsequence

    a_eq_lost_launch: assert property ( // RULE1
        eq_lost && !tx_active |=> state_q == ST_SEG1 && initiated_q)
        else $error("equalization loss did not launch");
    a_cts_off_train: assert property ( // RULE10
        tx_active |-> port_cts == '0)
        else $error("ready-for-sending on during training");
    a_seg1_preset: assert property ( // RULE18
        state_q == ST_SEG1 && seg_done |=> state_q == ST_EQ_TRAIN && scr_q == SCR_INIT)
        else $error("scrambler not preset at segment 2");
    a_seg4_to_data: assert property ( // RULE25
        state_q == ST_ONES && sym_tick && seg_cnt_q == SEG4_SYM - 12'h001
        |=> state_q == ST_DATA && port_cts == port_rts)
        else $error("segment 4 did not end in data");
    a_scr_feedback: assert property ( // RULE17
        scr_step |=> tx_bit_q == ($past(scr_in) ^ $past(scr_q[TAP_A]) ^ $past(scr_q[TAP_B]))
        && scr_q[0] == tx_bit_q)
        else $error("scrambler output wrong");
    a_desc_taps: assert property ( // RULE21
        rx_bit_valid |=> rx_data_q == ($past(rx_bit) ^ $past(desc_q[TAP_A]) ^
        $past(desc_q[TAP_B])) && rx_data_valid_q)
        else $error("descrambler output wrong");
    a_answer_once: assert property ( // RULE6
        s_ans_launch |=> state_q == ST_SEG1 && !pend_ans_q && !initiated_q)
        else $error("answer not sent exactly once");
    a_loop_all: assert property ( // RULE12
        loop_req_a && act_cfg_q != MUX_CFG_1 |-> &port_loop)
        else $error("local loop not on all ports");
    a_ovf_sticky: assert property ( // RULE27
        ovf_set != '0 |=> (ovf_q & $past(ovf_set)) == $past(ovf_set) ##1
        ((ovf_q | $past(buf_ovf_clr)) & $past(ovf_set, 2)) == $past(ovf_set, 2))
        else $error("overflow flag lost");
    a_guard_block: assert property ( // RULE5
        rx_fail && since_q < cfg_guard_cycles && !launch_cfg && !eq_lost &&
        !launch_retry && !launch_ans && state_q == ST_DATA |=> state_q == ST_DATA)
        else $error("resend inside guard time");

endmodule

`default_nettype wire

// file: tb/mrs_remote.sv
`default_nettype none
// Far-end modem: echoes the line, and lets the line wander between bits
module mrs_remote (
    // Clock
    input wire logic clk,
    // Line from the device
    input wire logic tx_bit,
    input wire logic tx_bit_valid,
    // Line back to the device
    output logic rx_bit,
    output logic rx_bit_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        rx_bit = 1'b0;
        rx_bit_valid = 1'b0;
    end
    // Toggling when idle so a stale bit is never mistaken for a fresh one
    always @(posedge clk) begin
        rx_bit_valid <= #2 tx_bit_valid;
        rx_bit <= #2 tx_bit_valid ? tx_bit : ~rx_bit;
    end
endmodule
`default_nettype wire

// file: tb/test_mrs_top.sv
`default_nettype none
module test_mrs_top
    import mrs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 0, reset_n = 0, eq_lost = 0, remote_sync_det = 0, rx_sync_ok = 0;
    logic rx_fail = 0, remote_cap_hi = 1, rate_hi_sw = 1, rate_sel_a_en = 0, rate_sel_a = 0;
    logic mux_en = 0, buf_init_on_sync = 0, loop_req_a = 0, test_all = 0;
    logic [3:0] mux_cfg_sw = 4'h1, active_cfg;
    logic [24:0] cfg_retry_cycles = 25'h00000c8, cfg_guard_cycles = 25'h00000c8;
    logic [1:0] tx_timing_mode = TXT_INT;
    logic [2:0] ext_timing_port = 3'h2;
    logic [5:0] port_dte_timing = 6'h3f, port_rts = 6'h3d, port_txd = 6'h15;
    logic [5:0] port_txd_valid = 0, test_port = 0, buf_ovf_clr = 0;
    logic [5:0] port_txd_ready, port_cts, port_loop, port_test_ind, buf_needed, buf_ovf;
    mrs_state_t tx_segment;
    logic tx_bit, tx_bit_valid, active_hi, rx_bit, rx_bit_valid, rx_data, rx_data_valid;
    logic [22:0] th, rh;
    logic rexp;
    int tn = 0, rn = 0, n_mismatch = 0, cmp_count = 0;

    mrs_top #(.SYM_DIV_P(8), .TRN_DIV_P(4)) dut (.sys_clk, .reset_n, .eq_lost,
        .remote_sync_det, .rx_sync_ok, .rx_fail, .remote_cap_hi, .rate_hi_sw,
        .rate_sel_a_en, .rate_sel_a, .mux_en, .mux_cfg_sw, .cfg_retry_cycles,
        .cfg_guard_cycles, .buf_init_on_sync, .tx_timing_mode, .ext_timing_port,
        .port_dte_timing, .port_rts, .port_txd, .port_txd_valid, .port_txd_ready,
        .port_cts, .loop_req_a, .port_loop, .test_port, .test_all, .port_test_ind,
        .buf_needed, .buf_ovf, .buf_ovf_clr, .tx_segment, .tx_bit, .tx_bit_valid,
        .active_cfg, .active_hi, .rx_bit, .rx_bit_valid, .rx_data, .rx_data_valid);
    mrs_remote far (.clk(sys_clk), .tx_bit, .tx_bit_valid, .rx_bit, .rx_bit_valid);

    always #25 sys_clk = ~sys_clk;

    task automatic chk(input logic [24:0] got, input logic [24:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %0h want %0h", $time, what, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask

    // Cycles spent in one segment; slack covers a launch between symbol ticks
    task automatic seg_len(input mrs_state_t s, input int n, input int slack);
        int c;
        c = 0;
        while (tx_segment !== s && c < 30000) begin tick(1); c++; end
        c = 0;
        while (tx_segment === s && c < 30000) begin tick(1); c++; end
        chk(25'(c <= n && c >= n - slack), 25'h1, "segment length");
    endtask

    always @(posedge sys_clk) begin
        if (tx_segment !== ST_EQ_TRAIN) tn <= 0;
        else if (tx_bit_valid) begin
            if (tn < 16) chk(tx_bit, 25'(tn % 4 == 3), "training pattern");
            if (tn >= 23) chk(tx_bit, 1'b1 ^ th[17] ^ th[22], "scrambler");
            th <= {th[21:0], tx_bit};
            tn <= tn + 1;
        end
        if (rx_data_valid && rn > 23) chk(rx_data, rexp, "descrambler");
        if (rx_bit_valid) begin
            rexp <= rx_bit ^ rh[17] ^ rh[22];
            rh <= {rh[21:0], rx_bit};
            rn <= rn + 1;
        end
    end

    task automatic report_and_stop;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Three full sequences plus margin
    initial begin
        #4500000;
        n_mismatch++;
        report_and_stop;
    end

    initial begin
        tick(20);
        chk(tx_segment, ST_IDLE, "reset state");
        reset_n = 1;
        tick(2);
        chk(tx_segment, ST_SEG1, "launch after reset");
        chk(port_cts, 6'h00, "cts in training");
        chk(buf_needed, 6'h3f, "buffer need internal");
        chk(active_hi, 1'b1, "launch rate");
        tx_timing_mode = TXT_EXT;
        loop_req_a = 1;
        test_port = 6'h04;
        tick(1);
        chk(buf_needed, 6'h3b, "buffer need external");
        chk(port_loop, 6'h01, "loop");
        chk(port_test_ind, 6'h04, "test per port");
        test_all = 1;
        port_txd_valid = 6'h02;
        tick(16);
        chk(port_test_ind, 6'h3f, "test all");
        chk(port_txd_ready[1], 1'b0, "buffer full");
        port_txd_valid = 0;
        port_rts = 6'h3f;
        tick(1);
        chk(port_txd_ready[1], 1'b1, "buffer flushed");
        port_txd_valid = 6'h02;
        tick(17);
        port_txd_valid = 0;
        chk(buf_ovf, 6'h02, "overflow sticky");
        buf_ovf_clr = 6'h02;
        tick(1);
        buf_ovf_clr = 0;
        chk(buf_ovf, 6'h00, "overflow clear");
        seg_len(ST_EQ_TRAIN, 2976 * 8, 0);
        seg_len(ST_RATE, 64 * 8, 0);
        seg_len(ST_ONES, 48 * 8, 0);
        tick(1);
        chk(port_cts, port_rts, "cts in data");
        seg_len(ST_DATA, 203, 8);
        cfg_retry_cycles = 25'h1ffffff;
        seg_len(ST_SEG1, 256 * 8, 8);
        seg_len(ST_ONES, 48 * 8, 0);
        tick(5);
        rx_fail = 1;
        tick(1);
        rx_fail = 0;
        chk(tx_segment, ST_DATA, "no resend in guard");
        remote_sync_det = 1;
        tick(2);
        remote_sync_det = 0;
        rx_sync_ok = 1;
        tick(1);
        rx_sync_ok = 0;
        chk(tx_segment, ST_SEG1, "answer sent");
        seg_len(ST_ONES, 48 * 8, 0);
        tick(5);
        chk(tx_segment, ST_DATA, "one answer only");
        eq_lost = 1;
        rate_hi_sw = 0;
        tick(1);
        eq_lost = 0;
        chk(tx_segment, ST_SEG1, "relaunch");
        chk(active_hi, 1'b1, "rate kept");
        chk(active_cfg, 4'h1, "config kept");
        chk(port_cts, 6'h00, "cts dropped");
        report_and_stop;
    end
endmodule
`default_nettype wire
